// ---- rtl/adc_conversion_serial_readout.sv ----
// conversion sequencing, sleep control and serial result readout
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1 - start falling edge begins conversion, holds sample, raises busy
// RQ2 - high-rate conversion ends, busy low, within 5 us of start
// RQ3 - busy falling loads the new result into the output register
// RQ4 - track/hold returns to tracking when busy falls, both modes
// RQ5 - start low at busy fall enters sleep; start high stays awake
// RQ6 - start rising edge wakes from sleep through a 5 us one-shot
// RQ7 - short wake pulse: hold taken 5 us after the waking edge
// RQ8 - long wake pulse: conversion ends 5 us after next falling edge
// RQ9 - host keeps wake pulse 40 ns to 2 us, or above 6 us
// RQ10 - output register stays readable while asleep
// RQ11 - read is 16 pulses; then shifter resets, output goes undriven
// RQ12 - data changes on falling clock edges, valid on both edges
// RQ13 - first zero driven on first rising edge
// RQ14 - two zeros then 14 result bits msb first; lsb on 15th fall
// RQ15 - lsb stays valid at 16th falling edge, then output disabled
// RQ16 - pulses past the 16th restart shifting; output stays driven
// RQ17 - start falling edge clears counter and shifter if clock low
// RQ18 - host keeps serial clock low at start fall and during conversion
// RQ19 - host returns clock low after a read until the next one
// RQ20 - read may come in bursts; bit position kept between them
// RQ21 - host ends reads 250 ns before start fall, never across it
// RQ22 - host serial clock up to 16 MHz
// RQ23 - host avoids reads during conversion and 250 ns before start
// RQ24 - result in two's complement bipolar, straight binary unipolar
// RQ25 - after power-up output undriven and busy low
module adc_conversion_serial_readout (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         serialClk,
  input  wire logic                         conversion_start_n,
  input  wire logic [adc_pkg::RESULT_W-1:0] sarCode,
  input  wire logic                         bipolarRange,
  output logic                              busy,
  output logic                              trackHold,
  output logic                              asleep,
  output logic                              serial_result_out,
  output logic                              serialResultOe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int ConvBound = adc_pkg::CONV_CYC + 1;

  logic [1:0]                   rstPipe;
  logic                         rstSyncN;
  logic                         csLevel;    // synced start pin
  logic                         sclkLevel;  // synced serial clock
  logic                         csPrev;
  logic                         csFall;
  logic                         csRise;
  adc_pkg::conv_state_t         state;
  logic [adc_pkg::CNT_W-1:0]    cnt;
  logic                         pending;    // start fell during wake
  logic                         startConv;
  logic                         doneConv;
  logic [adc_pkg::RESULT_W-1:0] sample;
  logic [adc_pkg::RESULT_W-1:0] resultReg;
  logic                         linkClear;

  readout_if rd ();

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // asserted at once, released after two clean clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= adc_pkg::RST_PIPE_INIT;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // ----------------------------------------------------------------
  // pin capture and edge detection
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH     (2),
    .RESET_VAL (adc_pkg::PIN_RESET_VAL)
  ) u_pin_sync (
    .clk      (clk),
    .rstN     (rstSyncN),
    .pinIn    ({conversion_start_n, serialClk}),
    .levelOut ({csLevel, sclkLevel})
  );

  // previous start level, reset high so power-up makes no edge
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      csPrev <= 1'b1;
    end else begin
      csPrev <= csLevel;
    end
  end
  assign csFall = csPrev & ~csLevel;
  assign csRise = ~csPrev & csLevel;

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  assign startConv =
    (state == adc_pkg::ST_AWAKE && csFall) ||
    (state == adc_pkg::ST_WAKE && cnt == '0 && (pending || csFall));
  assign doneConv = (state == adc_pkg::ST_CONVERT) && (cnt == '0);

  // one counter serves both the conversion timer and the wake one-shot
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state   <= adc_pkg::ST_AWAKE;
      cnt     <= '0;
      pending <= 1'b0;
    end else begin
      unique case (state)
        adc_pkg::ST_AWAKE: begin
          if (csFall) begin
            state <= adc_pkg::ST_CONVERT;                  // RQ1 RQ8
            cnt   <= adc_pkg::CNT_W'(adc_pkg::CONV_CYC - 1); // RQ2
          end
        end
        adc_pkg::ST_CONVERT: begin
          if (cnt == '0) begin
            // start level at busy fall picks the mode
            state <= csLevel ? adc_pkg::ST_AWAKE
                             : adc_pkg::ST_SLEEP;          // RQ5
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        adc_pkg::ST_SLEEP: begin
          if (csRise) begin
            state   <= adc_pkg::ST_WAKE;                   // RQ6
            cnt     <= adc_pkg::CNT_W'(adc_pkg::WAKE_CYC - 1);
            pending <= 1'b0;
          end
        end
        adc_pkg::ST_WAKE: begin
          if (cnt == '0) begin
            pending <= 1'b0;
            if (pending || csFall) begin
              // short pulse: sample taken when the one-shot expires
              state <= adc_pkg::ST_CONVERT;                // RQ7
              cnt   <= adc_pkg::CNT_W'(adc_pkg::CONV_CYC - 1);
            end else begin
              // long pulse: wait awake for the sampling edge
              state <= adc_pkg::ST_AWAKE;                  // RQ8
            end
          end else begin
            cnt <= cnt - 1'b1;
            if (csFall) begin
              pending <= 1'b1;                             // RQ7
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // busy covers a conversion already requested during wake-up
  assign busy = (state == adc_pkg::ST_CONVERT) ||
                (state == adc_pkg::ST_WAKE && pending);    // RQ1 RQ25
  assign trackHold = (state == adc_pkg::ST_CONVERT);       // RQ1 RQ4
  assign asleep    = (state == adc_pkg::ST_SLEEP);         // RQ5

  // ----------------------------------------------------------------
  // sample capture and output register
  // ----------------------------------------------------------------
  // the array value is taken as the track/hold goes into hold
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sample <= adc_pkg::RESULT_INIT;
    end else if (startConv) begin
      sample <= sarCode;                                   // RQ1
    end
  end

  // loaded only at busy fall; reads are kept out of the conversion,
  // so the link side sees a static word while it shifts
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      resultReg <= adc_pkg::RESULT_INIT;
    end else if (doneConv) begin
      resultReg <= adc_pkg::apply_coding(sample, bipolarRange); // RQ3 RQ24
    end
  end

  // ----------------------------------------------------------------
  // link clear on start falling edge
  // ----------------------------------------------------------------
  // held high in reset; a clear while the clock runs would tear a read,
  // so it is skipped when the clock is seen high
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      linkClear <= 1'b1;                                   // RQ25
    end else begin
      linkClear <= csFall & ~sclkLevel;                    // RQ17 RQ18
    end
  end

  // ----------------------------------------------------------------
  // serial side
  // ----------------------------------------------------------------
  assign rd.result    = resultReg;                         // RQ10
  assign rd.linkClear = linkClear;

  serial_shifter u_serial_shifter (
    .serialClk (serialClk),
    .rd        (rd.link)
  );

  assign serial_result_out = rd.dataOut;
  assign serialResultOe    = rd.dataOe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  sequence convStart_s;
    (state == adc_pkg::ST_AWAKE) && csFall;
  endsequence

  sequence wakeExpire_s;
    (state == adc_pkg::ST_WAKE) && (cnt == '0) && (pending || csFall);
  endsequence

  busy_rise_a: assert property (                           // RQ1
    convStart_s |=> (busy && trackHold))
    else $error("busy or hold missing after start edge");

  conv_time_a: assert property (                           // RQ2
    convStart_s |-> ##[1:ConvBound] !busy)
    else $error("conversion ran past its time limit");

  result_load_a: assert property (                         // RQ3
    doneConv |=> (resultReg ==
      adc_pkg::apply_coding($past(sample), $past(bipolarRange))))
    else $error("output register not loaded at busy fall");

  track_return_a: assert property (                        // RQ4
    $fell(busy) |-> !trackHold)
    else $error("track/hold still holding after busy fall");

  sleep_entry_a: assert property (                         // RQ5
    (doneConv && !csLevel) |=> (asleep && !busy))
    else $error("no sleep with start low at busy fall");

  stay_awake_a: assert property (                          // RQ5
    (doneConv && csLevel) |=> (state == adc_pkg::ST_AWAKE))
    else $error("slept with start high at busy fall");

  wake_len_a: assert property (                            // RQ6
    $rose(state == adc_pkg::ST_WAKE) |-> (!trackHold)[*8])
    else $error("hold taken before wake-up one-shot ran");

  wake_hold_a: assert property (                           // RQ7
    wakeExpire_s |=> (trackHold && busy))
    else $error("hold not taken when wake one-shot expired");

  clear_fall_a: assert property (                          // RQ17
    (csFall && !sclkLevel) |=> linkClear ##1 !linkClear)
    else $error("link clear not pulsed on start falling edge");

  clear_guard_a: assert property (                         // RQ17
    !(csFall && !sclkLevel) |=> !linkClear)
    else $error("link clear without a start falling edge");

endmodule : adc_conversion_serial_readout
`default_nettype wire

// ---- rtl/adc_pkg.sv ----
// shared constants, types and helpers for the converter control block
package adc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RESULT_W = 14;            // conversion result bits
  localparam int FRAME_W  = 16;            // two leading zeros + result
  localparam int CNT_W    = 10;            // sequencing counter width
  localparam int BITCNT_W = 4;             // serial falling-edge counter

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 125;      // core clock rate
  localparam int CONV_TIME_NS  = 5000;     // longest conversion time
  localparam int WAKE_TIME_NS  = 5000;     // typical wake-up one-shot
  localparam int PIN_SYNC_LAT  = 5;        // edges, pin to state change
  // longest time rounds down, and pin latency is taken off the budget
  localparam int CONV_CYC =
    CONV_TIME_NS * CLK_MHZ / 1000 - PIN_SYNC_LAT;
  localparam int WAKE_CYC =
    WAKE_TIME_NS * CLK_MHZ / 1000 - PIN_SYNC_LAT;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_RESET_VAL = 2'h2;  // start high, clock low
  localparam logic [1:0] RST_PIPE_INIT = 2'h0;
  localparam logic [RESULT_W-1:0] RESULT_INIT = 14'h0000;
  localparam logic [BITCNT_W-1:0] LAST_FALL   = 4'hf;   // 16th falling
  localparam logic [BITCNT_W-1:0] MSB_FALL    = 4'h1;   // 2nd falling
  localparam logic [BITCNT_W-1:0] LSB_FALL    = 4'he;   // 15th falling

  // ----------------------------------------------------------------
  // sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_CONVERT,
    ST_SLEEP,
    ST_WAKE
  } conv_state_t;

  // offset binary from the array; bipolar ranges flip the top bit
  function automatic logic [RESULT_W-1:0] apply_coding(
    input logic [RESULT_W-1:0] raw,
    input logic                bipolar
  );
    apply_coding = {raw[RESULT_W-1] ^ bipolar, raw[RESULT_W-2:0]};
  endfunction : apply_coding

endpackage : adc_pkg

// ---- rtl/pin_sync.sv ----
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ----------------------------------------------------------------
  // stages: the first is read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once two stages agree, filtering one glitch
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      levelOut <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          levelOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- rtl/readout_if.sv ----
// carrier between the conversion core and the serial shifter
`timescale 1ns/1ps
`default_nettype none
interface readout_if;
  logic [adc_pkg::RESULT_W-1:0] result;     // output register
  logic                         linkClear;  // async clear of link side
  logic                         dataOut;    // serial bit
  logic                         dataOe;     // serial pin driven

  modport core (
    output result,
    output linkClear,
    input  dataOut,
    input  dataOe
  );
  modport link (
    input  result,
    input  linkClear,
    output dataOut,
    output dataOe
  );
endinterface : readout_if
`default_nettype wire

// ---- rtl/serial_shifter.sv ----
// serial readout shifter running on the host's gated serial clock
`timescale 1ns/1ps
`default_nettype none
module serial_shifter (
  input  wire logic serialClk,
  readout_if.link   rd
);
  logic [adc_pkg::BITCNT_W-1:0] fallCnt;   // falling edges in frame
  logic                         startTog;  // toggled on frame start
  logic                         stopTog;   // toggled on 16th falling
  logic                         dout;
  logic                         framing;
  logic [adc_pkg::FRAME_W-1:0]  frame;

  assign framing = startTog ^ stopTog;
  assign frame   = {2'b00, rd.result};

  // ----------------------------------------------------------------
  // frame start on a rising edge: first zero is driven at once
  // ----------------------------------------------------------------
  // outside reset, clear is asserted only when the clock was seen low
  always_ff @(posedge serialClk or posedge rd.linkClear) begin
    if (rd.linkClear) begin
      startTog <= 1'b0;
    end else if (!framing && fallCnt == '0) begin
      startTog <= ~startTog;                      // RQ13 RQ16
    end
  end

  // ----------------------------------------------------------------
  // shifting on falling edges; position kept between bursts
  // ----------------------------------------------------------------
  always_ff @(negedge serialClk or posedge rd.linkClear) begin
    if (rd.linkClear) begin
      fallCnt <= '0;                              // RQ17
      stopTog <= 1'b0;
      dout    <= 1'b0;
    end else if (framing) begin
      fallCnt <= fallCnt + 1'b1;                  // RQ20
      if (fallCnt == adc_pkg::LAST_FALL) begin
        stopTog <= ~stopTog;                      // RQ11 RQ15
        dout    <= 1'b0;
      end else begin
        dout <= frame[4'(adc_pkg::FRAME_W - 2) - fallCnt]; // RQ12 RQ14
      end
    end
  end

  assign rd.dataOut = dout;
  assign rd.dataOe  = framing;                    // RQ11 RQ25

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  msb_first_a: assert property (                  // RQ14
    @(negedge serialClk) disable iff (rd.linkClear)
    (framing && fallCnt == adc_pkg::MSB_FALL)
      |=> (dout == rd.result[adc_pkg::RESULT_W-1]))
    else $error("msb not shifted on second falling edge");

  lsb_last_a: assert property (                   // RQ14
    @(negedge serialClk) disable iff (rd.linkClear)
    (framing && fallCnt == adc_pkg::LSB_FALL)
      |=> (dout == rd.result[0] && framing))
    else $error("lsb not shifted on fifteenth falling edge");

  // judged at the next rising edge: a 17th pulse restarts the frame
  frame_end_a: assert property (                  // RQ11
    @(posedge serialClk) disable iff (rd.linkClear)
    (framing && fallCnt == adc_pkg::LAST_FALL)
      |=> (!framing && fallCnt == '0))
    else $error("output not released after sixteenth falling edge");
endmodule : serial_shifter
`default_nettype wire

// ---- tb/host_model.sv ----
// host-side model: start pulses and gated serial reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic      startN,
  output logic      serialClk,
  input  wire logic serialData
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // 40 ns half period keeps the link at 12.5 MHz
  localparam realtime HALF = 40.0;

  // clock parked low outside frames
  initial begin
    startN = 1'b1;
    serialClk = 1'b0;
  end

  // callers only move start while the clock is parked low
  task automatic set_start(input logic level);
    startN = level;
  endtask : set_start

  // n pulses; bit taken late in the high phase, just before it changes
  task automatic read_bits(input int n, output logic [15:0] bits);
    bits = 16'h0000;
    #3.3;
    for (int i = 0; i < n; i++) begin
      serialClk = 1'b1;
      #(HALF - 4.0);
      bits = {bits[14:0], serialData};
      #4.0;
      serialClk = 1'b0;
      #HALF;
    end
  endtask : read_bits
endmodule : host_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  logic                         clk;
  logic                         rst_n;
  logic                         serialClk;
  logic                         startN;
  logic [adc_pkg::RESULT_W-1:0] sarCode;
  logic                         bipolarRange;
  logic                         busy;
  logic                         trackHold;
  logic                         asleep;
  logic                         serialOut;
  logic                         serialOe;
  wire                          pinLevel;
  int                           failures;
  int                           nTests;

  // undriven pin floats so a released output never reads as data
  assign pinLevel = serialOe ? serialOut : 1'bz;

  adc_conversion_serial_readout adc_conversion_serial_readout_inst (
    .clk                (clk),
    .rst_n              (rst_n),
    .serialClk          (serialClk),
    .conversion_start_n (startN),
    .sarCode            (sarCode),
    .bipolarRange       (bipolarRange),
    .busy               (busy),
    .trackHold          (trackHold),
    .asleep             (asleep),
    .serial_result_out  (serialOut),
    .serialResultOe     (serialOe)
  );

  host_model host_model_inst (
    .startN     (startN),
    .serialClk  (serialClk),
    .serialData (pinLevel)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (failures == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [15:0] got,
                            input logic [15:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    check_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask : check_bit

  // inputs other than the serial clock move 1 ns after the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  // bounded wait; running out ends the run
  task automatic wait_busy(input logic level, input int bound, inout int t);
    while (busy !== level) begin
      if (t >= bound) begin
        check_bit(busy, level, "busy wait ran out");
        complete_run();
      end
      cycles(1);
      t++;
    end
  endtask : wait_busy

  // whole read or two byte bursts, then quiet time before next start
  task automatic read_check(input logic [13:0] exp, input logic split);
    logic [15:0] hi;
    logic [15:0] lo;
    cycles(3);
    hi = 16'h0000;
    if (split) begin
      host_model_inst.read_bits(8, hi);
      cycles(20);
      host_model_inst.read_bits(8, lo);
      lo = {hi[7:0], lo[7:0]};
    end else begin
      host_model_inst.read_bits(16, lo);
    end
    check_word(lo, {2'b00, exp}, "frame");
    check_bit(serialOe, 1'b0, "pin driven after frame");
    cycles(40);
  endtask : read_check

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic convert(input logic [13:0] raw, input logic bip,
                         input logic keepLow, input logic split);
    int t;
    sarCode = raw;
    bipolarRange = bip;
    host_model_inst.set_start(1'b0);
    t = 0;
    wait_busy(1'b1, 8, t);
    check_bit(trackHold, 1'b1, "hold not taken");
    if (!keepLow) begin
      cycles(12);
      t += 12;
      host_model_inst.set_start(1'b1);
    end
    wait_busy(1'b0, 625, t);
    check_bit(trackHold, 1'b0, "still in hold");
    check_bit(serialOe, 1'b0, "shifter not cleared");
    cycles(2);
    check_bit(asleep, keepLow, "sleep entry");
    read_check({raw[13] ^ bip, raw[12:0]}, split);
  endtask : convert

  task automatic extra_pulses();
    logic [15:0] bits;
    host_model_inst.read_bits(16, bits);
    check_word(bits, 16'h3c03, "reread");
    host_model_inst.read_bits(1, bits);
    cycles(40);
    check_bit(serialOe, 1'b1, "pin released after extra pulse");
    convert(14'h0001, 1'b0, 1'b0, 1'b0);
  endtask : extra_pulses

  task automatic sleep_cycle();
    int t;
    convert(14'h3ffe, 1'b0, 1'b1, 1'b0);
    sarCode = 14'h0a0a;
    host_model_inst.set_start(1'b1);
    cycles(50);
    host_model_inst.set_start(1'b0);
    cycles(540);
    check_bit(trackHold, 1'b0, "hold taken early");
    t = 590;
    while (trackHold !== 1'b1 && t < 650) begin
      cycles(1);
      t++;
    end
    check_bit(trackHold, 1'b1, "no hold after wake");
    if (trackHold !== 1'b1) complete_run();
    t = 0;
    wait_busy(1'b0, 625, t);
    cycles(2);
    check_bit(asleep, 1'b1, "no sleep after wake");
    read_check(14'h0a0a, 1'b0);
    host_model_inst.set_start(1'b1);
    cycles(875);
    check_bit(asleep, 1'b0, "did not wake");
    check_bit(busy, 1'b0, "converting before start fell");
    convert(14'h2001, 1'b1, 1'b0, 1'b1);
  endtask : sleep_cycle

  initial begin
    rst_n = 1'b0;
    sarCode = 14'h0000;
    bipolarRange = 1'b0;
    failures = 0;
    nTests = 0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check_word({12'h000, busy, trackHold, asleep, serialOe},
               16'h0000, "reset state");
    cycles(12);
    convert(14'h2a5c, 1'b0, 1'b0, 1'b0);
    convert(14'h1c03, 1'b1, 1'b0, 1'b1);
    extra_pulses();
    sleep_cycle();
    complete_run();
  end
endmodule : tb
`default_nettype wire
